// File: rtl/cps_regs.svh
// Purpose: Offsets, field positions, reset values for the CPU priority status block
// Assumes: APB byte addresses, one 32-bit aligned word per register
// Notes:   Offsets are locally chosen
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

`define CPS_OFF_STATUS      12'h000
`define CPS_OFF_CORE_CTRL   12'h004
`define CPS_OFF_INT_CTRL1   12'h008
`define CPS_OFF_LEVEL       12'h00C

`define CPS_SR_RESET        16'h0000
`define CPS_CC_RESET        16'h0000
`define CPS_IC_RESET        16'h0000

`define CPS_SR_IPL_LSB      5
`define CPS_SR_IPL_MSB      7
`define CPS_SR_RA_BIT       4
`define CPS_SR_DA_BIT       9
`define CPS_SR_SAB_BIT      10
`define CPS_SR_OAB_BIT      11
`define CPS_CC_PRIORITY_LEVEL_HIGH_BIT_BIT     3
`define CPS_IC_NSTD_BIT     15
`define CPS_IPL_ALL_MASKED  3'h7

`endif

// File: rtl/cps_pkg.sv
// Purpose: Types shared by the CPU priority status block
// Assumes: Nothing beyond the register header
// Notes:   Bus states use Gray codes
package cps_pkg;
	typedef enum logic [1:0] {
		CPS_IDLE   = 2'b00,
		CPS_ACCESS = 2'b01
	} cps_bus_state_t;
	typedef logic [3:0] cps_level_t;
endpackage

// File: rtl/cps_level_if.sv
// Purpose: Carries priority inputs to the level evaluator and its results back
// Assumes: Single clock
// Notes:   Pure wires
interface cps_level_if;
	logic [2:0] field;
	logic       high_bit;
	logic [3:0] level;
	logic       user_block;
	modport eval (input field, input high_bit, output level, output user_block);
	modport user (output field, output high_bit, input level, input user_block);
endinterface

// File: rtl/cps_level_eval.sv
// Purpose: Forms the effective priority level and the user-interrupt block
// Assumes: Inputs come from registers on the same clock
// Notes:   Combinational only
`include "cps_regs.svh"
module cps_level_eval
	import cps_pkg::*;
(
	cps_level_if.eval lvl
);
	always_comb begin
		lvl.level = {lvl.high_bit, lvl.field};
		lvl.user_block = (lvl.field == `CPS_IPL_ALL_MASKED)
			| lvl.high_bit;
	end
endmodule

// File: rtl/cps_status.sv
// Purpose: CPU status register priority portion with APB access
// Assumes: APB master on i_ref_clk, synchronous active-high reset
// Notes:   Arithmetic flags are plain storage; summary bits clear on write of one
`include "cps_regs.svh"
//
// Contract
// - The priority field sits at status bits 7 to 5 and codes 000 to 111 mean levels 0 to 7.
// - The effective level is the core control high bit placed above the three-bit field.
// - User interrupts are blocked while the field holds 111.
// - User interrupts are blocked while the core control high bit is one.
// - Software writes to the field are ignored while the nesting disable bit is one.
module cps_status
	import cps_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_srst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	input  wire logic        i_repeat_active,
	input  wire logic        i_accum_overflow_set,
	input  wire logic        i_accum_saturation_set,
	input  wire logic        i_dsp_active,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata,
	output logic [3:0]       o_priority_level,
	output logic             o_user_irq_block
);
	cps_bus_state_t state_ff;
	logic [15:0]    cpu_status_ff;
	logic [15:0]    core_control_reg_ff;
	logic [15:0]    interrupt_control_first_ff;
	logic [31:0]    nxt_prdata;
	logic           nxt_pslverr;
	logic           wr_en;
	logic           rd_en;
	logic           lo_en;
	logic           hi_en;
	logic [15:0]    wr_mask;
	logic [15:0]    sr_wdata;

	cps_level_if lvl ();

	cps_level_eval u_eval (
		.lvl (lvl)
	);

	assign lvl.field    = cpu_status_ff[`CPS_SR_IPL_MSB:`CPS_SR_IPL_LSB];
	assign lvl.high_bit = core_control_reg_ff[`CPS_CC_PRIORITY_LEVEL_HIGH_BIT_BIT];

	function automatic logic is_mapped(input logic [11:0] addr);
		is_mapped = (addr == `CPS_OFF_STATUS) || (addr == `CPS_OFF_CORE_CTRL) ||
			(addr == `CPS_OFF_INT_CTRL1) || (addr == `CPS_OFF_LEVEL);
	endfunction

	// No wait state: setup, then access answered in its first cycle
	assign wr_en   = (state_ff == CPS_ACCESS) && i_psel && i_penable && i_pwrite &&
		is_mapped(i_paddr);
	assign rd_en   = (state_ff == CPS_ACCESS) && i_psel && i_penable && !i_pwrite;
	assign lo_en   = i_pstrb[0];
	assign hi_en   = i_pstrb[1];
	assign wr_mask = {{8{hi_en}}, {8{lo_en}}};

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_ff <= CPS_IDLE;
		end else if (i_psel && !i_penable) begin
			state_ff <= CPS_ACCESS;
		end else begin
			state_ff <= CPS_IDLE;
		end
	end

	always_comb begin
		nxt_pslverr = 1'b0;
		nxt_prdata  = 32'h0000_0000;
		if (!is_mapped(i_paddr)) begin
			nxt_pslverr = 1'b1;
		end else begin
			unique case (i_paddr)
				`CPS_OFF_STATUS:    nxt_prdata = {16'h0000, cpu_status_ff};
				`CPS_OFF_CORE_CTRL: nxt_prdata = {16'h0000, core_control_reg_ff};
				`CPS_OFF_INT_CTRL1: nxt_prdata = {16'h0000, interrupt_control_first_ff};
				default:            nxt_prdata = {27'h0000000, lvl.user_block, lvl.level};
			endcase
		end
	end

	// Answer pulses for one cycle; master holds the request until it sees it
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else if (i_psel && !i_penable) begin
			o_pready  <= 1'b1;
			o_pslverr <= nxt_pslverr;
			o_prdata  <= i_pwrite ? 32'h0000_0000 : nxt_prdata;
		end else begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end
	end

	always_comb begin
		sr_wdata = i_pwdata[15:0];
		// Locked field keeps its value rather than taking the write
		if (interrupt_control_first_ff[`CPS_IC_NSTD_BIT]) begin
			sr_wdata[`CPS_SR_IPL_MSB:`CPS_SR_IPL_LSB] =
				cpu_status_ff[`CPS_SR_IPL_MSB:`CPS_SR_IPL_LSB];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			cpu_status_ff <= `CPS_SR_RESET;
		end else begin
			if (wr_en && i_paddr == `CPS_OFF_STATUS) begin
				cpu_status_ff <= (cpu_status_ff & ~wr_mask) | (sr_wdata & wr_mask);
				// Summary bits only clear: writing one clears, zero keeps
				cpu_status_ff[`CPS_SR_OAB_BIT] <= cpu_status_ff[`CPS_SR_OAB_BIT] &
					~(hi_en & i_pwdata[`CPS_SR_OAB_BIT]);
				cpu_status_ff[`CPS_SR_SAB_BIT] <= cpu_status_ff[`CPS_SR_SAB_BIT] &
					~(hi_en & i_pwdata[`CPS_SR_SAB_BIT]);
			end
			// Hardware sets win over a clear in the same cycle
			if (i_accum_overflow_set) begin
				cpu_status_ff[`CPS_SR_OAB_BIT] <= 1'b1;
			end
			if (i_accum_saturation_set) begin
				cpu_status_ff[`CPS_SR_SAB_BIT] <= 1'b1;
			end
			// Read-only status follows the core, never the bus
			cpu_status_ff[`CPS_SR_RA_BIT] <= i_repeat_active;
			cpu_status_ff[`CPS_SR_DA_BIT] <= i_dsp_active;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			core_control_reg_ff <= `CPS_CC_RESET;
		end else if (wr_en && i_paddr == `CPS_OFF_CORE_CTRL) begin
			core_control_reg_ff <= (core_control_reg_ff & ~wr_mask) |
				(i_pwdata[15:0] & wr_mask);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			interrupt_control_first_ff <= `CPS_IC_RESET;
		end else if (wr_en && i_paddr == `CPS_OFF_INT_CTRL1) begin
			interrupt_control_first_ff <= (interrupt_control_first_ff & ~wr_mask) |
				(i_pwdata[15:0] & wr_mask);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_priority_level <= 4'h0;
			o_user_irq_block <= 1'b0;
		end else begin
			o_priority_level <= lvl.level;
			o_user_irq_block <= lvl.user_block;
		end
	end

	logic unused_rd;
	assign unused_rd = rd_en;
endmodule

// File: test/cps_status_assertions.sv
// Purpose: Port checks for cps_status
// Assumes: One clock, sync reset
// Notes:   Bound below
`include "cps_regs.svh"
module cps_status_assertions (
	input wire logic        i_ref_clk,
	input wire logic        i_srst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0]  i_pstrb,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [31:0] o_prdata,
	input wire logic [3:0]  o_priority_level,
	input wire logic        o_user_irq_block
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_cc_wr;
		i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0]
			&& i_paddr == `CPS_OFF_CORE_CTRL;
	endsequence
	AST_RST: assert property (disable iff (1'b0) i_srst |=>
		o_priority_level == 4'h0 && !o_user_irq_block) else $error("Outputs not cleared");
	AST_BLK: assert property (o_user_irq_block ==
		(o_priority_level[3] || &o_priority_level[2:0])) else $error("Block wrong");
	AST_HIGH: assert property (s_cc_wr |-> ##2
		o_priority_level[3] == $past(i_pwdata[3], 2)) else $error("High bit wrong");
	AST_ANSWER: assert property (s_setup |=> o_pready) else $error("No answer");
	AST_ERR: assert property (o_pslverr |-> o_pready) else $error("Stray error");
	AST_IDLE: assert property (!o_pready |-> o_prdata == 32'h0) else $error("Stray data");
endmodule
bind cps_status cps_status_assertions chk_u (.*);

// File: test/test_cps_status.sv
// Purpose: Self-checking bench for cps_status
// Assumes: APB answer one cycle after setup
// Notes:   Core-side inputs stay low except in the flag test
`include "cps_regs.svh"
module test_cps_status;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, srst, psel, pen, pwr, rdy, err, blk, re, ra, dsa, ovs, sas;
	logic [11:0] addr;
	logic [31:0] wd, rd, prd;
	logic [3:0]  lvl;
	int          num_errors, samples_checked, cyc;
	cps_status dut_u (.i_ref_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'hF),
		.i_repeat_active(ra), .i_accum_overflow_set(ovs),
		.i_accum_saturation_set(sas), .i_dsp_active(dsa), .o_pready(rdy),
		.o_pslverr(err), .o_prdata(prd), .o_priority_level(lvl), .o_user_irq_block(blk));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = prd;
		re = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_reset;
		logic [11:0] offs [4] = '{`CPS_OFF_STATUS, `CPS_OFF_CORE_CTRL,
			`CPS_OFF_INT_CTRL1, `CPS_OFF_LEVEL};
		foreach (offs[i]) begin
			apb(1'b0, offs[i], 32'h0);
			chk("reset", rd, 32'h0);
		end
		apb(1'b1, `CPS_OFF_STATUS, 32'h10);
		apb(1'b0, `CPS_OFF_STATUS, 32'h0);
		chk("ro_bit", rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", {rd[30:0], re}, 32'h1);
		$display("reset test done");
	endtask
	// High bit off then on; covers all eight field codes each time
	task automatic t_levels(input logic hi);
		apb(1'b1, `CPS_OFF_CORE_CTRL, {28'h0, hi, 3'h0});
		for (int v = 0; v < 8; v++) begin
			apb(1'b1, `CPS_OFF_STATUS, 32'(v << 5));
			apb(1'b0, `CPS_OFF_STATUS, 32'h0);
			chk("field", rd, 32'(v << 5));
			apb(1'b0, `CPS_OFF_LEVEL, 32'h0);
			chk("level_reg", rd, {27'h0, hi || v == 7, hi, 3'(v)});
			chk("level", {27'h0, blk, lvl}, {27'h0, hi || v == 7, hi, 3'(v)});
		end
		$display("level test done");
	endtask
	task automatic t_nest;
		apb(1'b1, `CPS_OFF_STATUS, 32'h60);
		apb(1'b1, `CPS_OFF_INT_CTRL1, 32'h8000);
		apb(1'b1, `CPS_OFF_STATUS, 32'hA0);
		apb(1'b0, `CPS_OFF_STATUS, 32'h0);
		chk("locked", rd, 32'h60);
		apb(1'b1, `CPS_OFF_INT_CTRL1, 32'h0);
		apb(1'b1, `CPS_OFF_STATUS, 32'hA0);
		apb(1'b0, `CPS_OFF_STATUS, 32'h0);
		chk("unlocked", rd, 32'hA0);
		$display("nesting test done");
	endtask
	// Core-fed bits: mirrors follow the core, summary bits set by it and cleared by software
	task automatic t_flags;
		ra <= 1'b1;
		dsa <= 1'b1;
		ovs <= 1'b1;
		sas <= 1'b1;
		@(posedge clk);
		ovs <= 1'b0;
		apb(1'b1, `CPS_OFF_STATUS, 32'h0);
		apb(1'b0, `CPS_OFF_STATUS, 32'h0);
		chk("core_bits", rd, 32'h0E10);
		apb(1'b1, `CPS_OFF_STATUS, 32'h800);
		apb(1'b0, `CPS_OFF_STATUS, 32'h0);
		chk("sum_clear", rd, 32'h0610);
		apb(1'b1, `CPS_OFF_STATUS, 32'h400);
		sas <= 1'b0;
		apb(1'b0, `CPS_OFF_STATUS, 32'h0);
		chk("set_wins", rd, 32'h0610);
		apb(1'b1, `CPS_OFF_STATUS, 32'h400);
		apb(1'b0, `CPS_OFF_STATUS, 32'h0);
		chk("sab_clear", rd, 32'h0210);
		ra <= 1'b0;
		dsa <= 1'b0;
		apb(1'b1, `CPS_OFF_STATUS, 32'h210);
		apb(1'b0, `CPS_OFF_STATUS, 32'h0);
		chk("ro_bits", rd, 32'h0);
		$display("flag test done");
	endtask
	// Reset in mid-run must clear what earlier transfers left set
	task automatic t_rerst;
		apb(1'b1, `CPS_OFF_CORE_CTRL, 32'h8);
		apb(1'b1, `CPS_OFF_STATUS, 32'hE0);
		apb(1'b1, `CPS_OFF_INT_CTRL1, 32'h8000);
		chk("pre_reset", {27'h0, blk, lvl}, 32'h1F);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("reset_pins", {27'h0, blk, lvl}, 32'h0);
		srst <= 1'b0;
		t_reset();
		$display("mid-run reset test done");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Ceiling well above the roughly 250 cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		{srst, psel, pen, pwr, addr, wd} = {1'b1, 47'h0};
		{ra, dsa, ovs, sas} = 4'h0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_levels(1'b0);
		t_levels(1'b1);
		t_nest();
		t_flags();
		t_rerst();
		close_out();
	end
endmodule
